// ==== design/mdsc_regs.sv ====
// Purpose: miscellaneous control and dual-scan colour control registers on the sequencer data port
// Assumes: index and data strobes come from bus logic on clk; pixel tick and suspend arrive asynchronously
// Notes: bits 3:0 of the misc register are write-only and read as zero
//
// Overview of operation
// - ready bit set adds three wait states
// - command-timing bit adds one cycle of delay at cmd_sampled
// - divide-by-four bit quarters pixel clock
// - oscillator-gate bit disables pad in suspend
// - bits 1,0 select DRAM/CPU input thresholds
// - bits 3:0 write-only; all reset zero
// - bit 7 selects refresh cycles per line
// - bit 6 selects dual-scan colour panel mode
// - bit 5 balances CPU against video bandwidth
`include "mdsc_consts.svh"
module mdsc_regs (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // index/data port
  input wire logic [7:0] seq_index,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire mdsc_pkg::mdsc_byte_t wr_data,
  output mdsc_pkg::mdsc_byte_t rd_data,
  // memory-cycle ready handshake
  input wire logic mem_cycle_start,
  output logic mem_ready,
  // asynchronous inputs
  input wire logic cmd_pin,
  input wire logic pix_tick_in,
  input wire logic suspend_in,
  // control outputs
  output logic cmd_sampled,
  output logic pix_tick_out,
  output logic osc_pad_en,
  output logic dram_cmos_sel,
  output logic cpu_cmos_sel,
  output logic refresh_per_line_sel,
  output logic dual_scan_color_sel,
  output logic cpu_bw_priority
);
  import mdsc_pkg::*;

  mdsc_byte_t misc_q, misc_d, dscc_q, dscc_d, rdata_q, rdata_d;
  logic [1:0] cmd_sync_q, pix_sync_q, susp_sync_q;
  logic cmd_neg_q, cmd_late_q, cmd_out_q, cmd_out_d;
  logic osc_q, osc_d, dram_q, cpu_q, rfl_q, dual_q, bw_q;
  logic dram_d, cpu_d, rfl_d, dual_d, bw_d;
  mdsc_rdy_state_t rs_q, rs_d;
  logic [1:0] wcnt_q, wcnt_d;
  logic rdy_q, rdy_d;

  // register writes and reads; reserved bits never stored
  always_comb begin
    misc_d = misc_q;
    dscc_d = dscc_q;
    rdata_d = rdata_q;
    if (wr_stb && seq_index == `MDSC_IDX_MISC2)
      misc_d = wr_data & `MDSC_MISC2_WMASK;
    if (wr_stb && seq_index == `MDSC_IDX_DSCC)
      dscc_d = wr_data & `MDSC_DSCC_WMASK;
    if (rd_stb) begin
      if (seq_index == `MDSC_IDX_MISC2)
        rdata_d = misc_q & `MDSC_MISC2_RW_MASK;
      else if (seq_index == `MDSC_IDX_DSCC)
        rdata_d = dscc_q;
      else
        rdata_d = `MDSC_RESET_VAL;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      misc_q <= `MDSC_RESET_VAL;
      dscc_q <= `MDSC_RESET_VAL;
      rdata_q <= `MDSC_RESET_VAL;
    end else if (ce) begin
      misc_q <= misc_d;
      dscc_q <= dscc_d;
      rdata_q <= rdata_d;
    end
  end

  // two-flop synchronisers for the pin inputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmd_sync_q <= 2'h0;
      pix_sync_q <= 2'h0;
      susp_sync_q <= 2'h0;
    end else if (ce) begin
      cmd_sync_q <= {cmd_sync_q[0], cmd_pin};
      pix_sync_q <= {pix_sync_q[0], pix_tick_in};
      susp_sync_q <= {susp_sync_q[0], suspend_in};
    end
  end

  // half-clock delay: the synced command level is re-taken on the falling edge
  always_ff @(negedge clk or posedge rst) begin
    if (rst)
      cmd_neg_q <= 1'b0;
    else if (ce)
      cmd_neg_q <= cmd_sync_q[1];
  end

  // rising-edge logic only sees the late sample one edge later, so the
  // delayed mode shows up as one extra cycle at the port
  always_comb begin
    cmd_out_d = misc_q[`MDSC_MISC2_CMD_BIT] ? cmd_late_q : cmd_sync_q[1];
    osc_d = ~(misc_q[`MDSC_MISC2_OSC_BIT] & susp_sync_q[1]);
    dram_d = misc_q[`MDSC_MISC2_DRAM_BIT];
    cpu_d = misc_q[`MDSC_MISC2_CPU_BIT];
    rfl_d = dscc_q[`MDSC_DSCC_RFL_BIT];
    dual_d = dscc_q[`MDSC_DSCC_DUAL_BIT];
    bw_d = dscc_q[`MDSC_DSCC_BW_BIT];
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmd_late_q <= 1'b0;
      cmd_out_q <= 1'b0;
      osc_q <= 1'b1;
      dram_q <= 1'b0;
      cpu_q <= 1'b0;
      rfl_q <= 1'b0;
      dual_q <= 1'b0;
      bw_q <= 1'b0;
    end else if (ce) begin
      cmd_late_q <= cmd_neg_q;
      cmd_out_q <= cmd_out_d;
      osc_q <= osc_d;
      dram_q <= dram_d;
      cpu_q <= cpu_d;
      rfl_q <= rfl_d;
      dual_q <= dual_d;
      bw_q <= bw_d;
    end
  end

  // ready sequencer: minimum delay answers the cycle after start
  always_comb begin
    rs_d = rs_q;
    wcnt_d = wcnt_q;
    rdy_d = 1'b0;
    case (rs_q)
      MDSC_IDLE: begin
        if (mem_cycle_start) begin
          if (misc_q[`MDSC_MISC2_RDY_BIT]) begin
            rs_d = MDSC_WAIT;
            wcnt_d = `MDSC_RDY_EXTRA_WAITS;
          end else begin
            rs_d = MDSC_DONE;
            rdy_d = 1'b1;
          end
        end
      end
      MDSC_WAIT: begin
        wcnt_d = wcnt_q - 2'h1;
        if (wcnt_q == 2'h1) begin
          rs_d = MDSC_DONE;
          rdy_d = 1'b1;
        end
      end
      MDSC_DONE: rs_d = MDSC_IDLE;
      default: rs_d = MDSC_IDLE;
    endcase
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rs_q <= MDSC_IDLE;
      wcnt_q <= 2'h0;
      rdy_q <= 1'b0;
    end else if (ce) begin
      rs_q <= rs_d;
      wcnt_q <= wcnt_d;
      rdy_q <= rdy_d;
    end
  end

  mdsc_div4 u_div4 (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .div_en(misc_q[`MDSC_MISC2_DIV4_BIT]),
    .pix_tick(pix_sync_q[1]),
    .pix_tick_out(pix_tick_out)
  );

  assign rd_data = rdata_q;
  assign mem_ready = rdy_q;
  assign cmd_sampled = cmd_out_q;
  assign osc_pad_en = osc_q;
  assign dram_cmos_sel = dram_q;
  assign cpu_cmos_sel = cpu_q;
  assign refresh_per_line_sel = rfl_q;
  assign dual_scan_color_sel = dual_q;
  assign cpu_bw_priority = bw_q;
endmodule

// ==== design/mdsc_consts.svh ====
// Purpose: offsets, field positions, reset values and timing counts for the sequencer control pair
// Assumes: index-addressed 8-bit data port, one clock
// Notes: included by bare name
`ifndef MDSC_CONSTS_SVH
`define MDSC_CONSTS_SVH
`define MDSC_IDX_MISC2 8'h16
`define MDSC_IDX_DSCC 8'h1a
`define MDSC_MISC2_RDY_BIT 5
`define MDSC_MISC2_CMD_BIT 4
`define MDSC_MISC2_DIV4_BIT 3
`define MDSC_MISC2_OSC_BIT 2
`define MDSC_MISC2_DRAM_BIT 1
`define MDSC_MISC2_CPU_BIT 0
`define MDSC_DSCC_RFL_BIT 7
`define MDSC_DSCC_DUAL_BIT 6
`define MDSC_DSCC_BW_BIT 5
`define MDSC_MISC2_RW_MASK 8'h30
`define MDSC_MISC2_WMASK 8'h3f
`define MDSC_DSCC_WMASK 8'he0
`define MDSC_RESET_VAL 8'h00
`define MDSC_RDY_EXTRA_WAITS 2'h3
`endif

// ==== design/mdsc_pkg.sv ====
// Purpose: shared types for the sequencer control pair
// Assumes: nothing beyond the constants header
// Notes: one-hot ready sequencer states
package mdsc_pkg;
  typedef logic [7:0] mdsc_byte_t;
  typedef enum logic [2:0] {
    MDSC_IDLE = 3'b001,
    MDSC_WAIT = 3'b010,
    MDSC_DONE = 3'b100
  } mdsc_rdy_state_t;
endpackage

// ==== design/mdsc_div4.sv ====
// Purpose: optional divide-by-four of the pixel clock, as a clock enable
// Assumes: pixel clock sampled in the register clock domain already
// Notes: output is a registered enable pulse, not a derived clock
`include "mdsc_consts.svh"
module mdsc_div4 (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // control
  input wire logic div_en,
  input wire logic pix_tick,
  // result
  output logic pix_tick_out
);
  logic [1:0] cnt_q, cnt_d;
  logic out_q, out_d;
  always_comb begin
    cnt_d = cnt_q;
    out_d = 1'b0;
    if (pix_tick) begin
      if (div_en) begin
        cnt_d = cnt_q + 2'h1;
        out_d = (cnt_q == 2'h3);
      end else begin
        cnt_d = 2'h0;
        out_d = 1'b1;
      end
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 2'h0;
      out_q <= 1'b0;
    end else if (ce) begin
      cnt_q <= cnt_d;
      out_q <= out_d;
    end
  end
  assign pix_tick_out = out_q;
endmodule

// ==== sim/mdsc_regs_properties.sv ====
// Purpose: port checks for the sequencer control pair
// Assumes: ce held high, one clock
// Notes: bound to mdsc_regs below
module mdsc_regs_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [7:0] seq_index,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire mdsc_pkg::mdsc_byte_t wr_data,
  input wire mdsc_pkg::mdsc_byte_t rd_data,
  input wire logic mem_cycle_start,
  input wire logic mem_ready,
  input wire logic suspend_in,
  input wire logic osc_pad_en,
  input wire logic dram_cmos_sel,
  input wire logic cpu_cmos_sel,
  input wire logic refresh_per_line_sel,
  input wire logic dual_scan_color_sel,
  input wire logic cpu_bw_priority
);
  import mdsc_pkg::*;
  default clocking dc @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_wm; ce && wr_stb && seq_index == 8'h16; endsequence
  sequence s_wd; ce && wr_stb && seq_index == 8'h1a; endsequence
  sequence s_rd(logic [7:0] i); ce && rd_stb && seq_index == i; endsequence
  sequence s_slow; mem_cycle_start ##1 !mem_ready; endsequence
  property p_thr; s_wm |-> ##2 {dram_cmos_sel, cpu_cmos_sel} == $past(wr_data[1:0], 2); endproperty
  a_thr: assert property (p_thr) else $error("threshold select mismatch");
  property p_dsc; s_wd |-> ##2 {refresh_per_line_sel, dual_scan_color_sel, cpu_bw_priority} ==
    $past(wr_data[7:5], 2); endproperty
  a_dsc: assert property (p_dsc) else $error("dual-scan outputs mismatch");
  property p_mrd; s_rd(8'h16) |=> rd_data[7:6] == 2'h0 && rd_data[3:0] == 4'h0; endproperty
  a_mrd: assert property (p_mrd) else $error("misc readback not masked");
  property p_drd; s_rd(8'h1a) |=> rd_data[4:0] == 5'h0; endproperty
  a_drd: assert property (p_drd) else $error("dual-scan reserved bits read back");
  property p_unm; ce && rd_stb && seq_index != 8'h16 && seq_index != 8'h1a |=> rd_data == 8'h00; endproperty
  a_unm: assert property (p_unm) else $error("unmapped index read nonzero");
  property p_slow; s_slow |-> !mem_ready [*3] ##1 mem_ready; endproperty
  a_slow: assert property (p_slow) else $error("delayed ready not at fourth cycle");
  property p_one; mem_ready |=> !mem_ready; endproperty
  a_one: assert property (p_one) else $error("ready longer than one cycle");
  property p_osc; !osc_pad_en |-> $past(suspend_in, 2) || $past(suspend_in, 3) || $past(suspend_in, 4); endproperty
  a_osc: assert property (p_osc) else $error("pad disabled outside suspend");
endmodule
bind mdsc_regs mdsc_regs_chk mdsc_regs_chk_inst (.clk, .rst, .ce, .seq_index, .wr_stb, .rd_stb, .wr_data,
  .rd_data, .mem_cycle_start, .mem_ready, .suspend_in, .osc_pad_en, .dram_cmos_sel, .cpu_cmos_sel,
  .refresh_per_line_sel, .dual_scan_color_sel, .cpu_bw_priority);

// ==== sim/mdsc_host_pins.sv ====
// Purpose: host board pins: pixel ticks, suspend, refresh source
// Assumes: shares the block clock
// Notes: levels move only on edges
module mdsc_host_pins (
  // clock
  input wire logic clk,
  // bench requests
  input wire logic tick_en,
  input wire logic susp_req,
  // pins to the block
  output logic pix_tick_in,
  output logic suspend_in,
  output logic refresh_source_select,
  output logic [1:0] panel_type_field
);
  // colour panel pattern, so dual-scan colour may be selected
  assign panel_type_field = 2'h2;
  // external slow refresh always present, so the pad gate is legal
  assign refresh_source_select = 1'b0;
  always_ff @(posedge clk) begin
    pix_tick_in <= tick_en;
    suspend_in <= susp_req;
  end
endmodule

// ==== sim/mdsc_regs_bench.sv ====
// Purpose: directed bench for mdsc_regs
// Assumes: one clock; enable and command pin driven here
// Notes: inputs move 5 ns after the rising edge
module mdsc_regs_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import mdsc_pkg::*;
  logic clk, rst, wr_stb, rd_stb, mem_cycle_start, mem_ready, cmd_sampled, pix_tick_out, osc_pad_en;
  logic dram_cmos_sel, cpu_cmos_sel, refresh_per_line_sel, dual_scan_color_sel, cpu_bw_priority;
  logic pix_tick_in, suspend_in, refresh_source_select, tick_en, susp_req, ce, cmd_pin;
  logic [1:0] panel_type_field;
  logic [7:0] seq_index;
  mdsc_byte_t wr_data, rd_data;
  int num_errors, check_count, n;
  mdsc_regs mdsc_regs_inst (.*);
  mdsc_host_pins mdsc_host_pins_inst (.*);
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #5;
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    seq_index = i;
    wr_data = d;
    wr_stb = 1;
    tick(1);
    wr_stb = 0;
  endtask
  task automatic rd(input logic [7:0] i, input logic [7:0] exp);
    seq_index = i;
    rd_stb = 1;
    tick(1);
    rd_stb = 0;
    chk("read data", rd_data, exp);
  endtask
  task automatic rdy(input logic [7:0] exp);
    mem_cycle_start = 1;
    tick(1);
    mem_cycle_start = 0;
    for (n = 1; mem_ready !== 1'b1 && n < 20; n++) tick(1);
    chk("ready latency", n[7:0], exp);
    tick(2);
  endtask
  task automatic pix(input logic [7:0] exp);
    tick(4);
    n = 0;
    repeat (16) begin
      tick(1);
      n += pix_tick_out;
    end
    chk("pixel ticks", n[7:0], exp);
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  initial begin
    {rst, wr_stb, rd_stb, mem_cycle_start, tick_en, susp_req, seq_index, wr_data} = {1'b1, 21'h0};
    {num_errors, check_count} = 0;
    ce = 1;
    cmd_pin = 0;
    tick(3);
    rst = 0;
    chk("pad enable", {7'h0, osc_pad_en}, 8'h01);
    chk("selects", {3'h0, dram_cmos_sel, cpu_cmos_sel, refresh_per_line_sel, dual_scan_color_sel,
      cpu_bw_priority}, 8'h00);
    rd(8'h1a, 8'h00);
    wr(8'h16, 8'hff);
    rd(8'h16, 8'h30);
    chk("thresholds", {6'h0, dram_cmos_sel, cpu_cmos_sel}, 8'h03);
    cmd_pin = 1;
    tick(3);
    chk("command delayed", {7'h0, cmd_sampled}, 8'h00);
    tick(1);
    chk("command delayed", {7'h0, cmd_sampled}, 8'h01);
    rdy(8'h04);
    if (panel_type_field === 2'h2) wr(8'h1a, 8'hff);
    rd(8'h1a, 8'he0);
    chk("dual outs", {5'h0, refresh_per_line_sel, dual_scan_color_sel, cpu_bw_priority}, 8'h07);
    ce = 0;
    wr(8'h1a, 8'h00);
    ce = 1;
    rd(8'h1a, 8'he0);
    wr(8'h17, 8'hff);
    rd(8'h17, 8'h00);
    wr(8'h16, 8'h08);
    tick_en = 1;
    pix(8'h04);
    wr(8'h16, 8'h00);
    pix(8'h10);
    rdy(8'h01);
    cmd_pin = 0;
    tick(3);
    chk("command plain", {7'h0, cmd_sampled}, 8'h00);
    susp_req = 1;
    tick(6);
    chk("pad kept", {7'h0, osc_pad_en}, 8'h01);
    if (refresh_source_select === 1'b0) wr(8'h16, 8'h04);
    tick(6);
    chk("pad gated", {7'h0, osc_pad_en}, 8'h00);
    susp_req = 0;
    tick(6);
    chk("pad back", {7'h0, osc_pad_en}, 8'h01);
    end_of_test;
  end
endmodule
